// file: pkg/ssh_pkg.sv
// Shared constants and types for the sensor serial port
`default_nettype none
package ssh_pkg;
	localparam logic [5:0] I2C_ADDR_HI    = 6'h3b;
	localparam logic [7:0] CFG_ADDR       = 8'hf5;
	localparam int         THREE_WIRE_BIT = 0;
	localparam logic       SPI_ADDR_MSB   = 1'b1;
	localparam logic       RW_WRITE       = 1'b0;
	localparam logic       RW_READ        = 1'b1;
	localparam logic [7:0] RESET_ADDR     = 8'h00;
	localparam logic       RESET_3W       = 1'b0;
	localparam logic [3:0] I2C_ACK_BIT    = 4'h8;
	localparam logic [3:0] BYTE_LAST      = 4'h7;
	localparam logic [3:0] PIN_IDLE       = 4'hf;
	// Host bit timing: one bit is four quarters of the serial clock
	localparam int         REF_PERIOD_NS  = 5;
	localparam int         QUARTER_NS     = 80;
	localparam int         QUARTER_CYCLES =
		(QUARTER_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	localparam logic [4:0] QUARTER_TOP    = 5'(QUARTER_CYCLES - 1);
	typedef enum logic [2:0] {
		DI_IDLE, DI_ADDR, DI_REG, DI_WDAT, DI_RDAT, DI_SKIP
	} ssh_i2c_e;
	typedef enum logic [1:0] {SP_CTRL, SP_DATA, SP_READ} ssh_spi_e;
	typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} ssh_host_e;
endpackage
`default_nettype wire

// file: pkg/ssh_if.sv
// Serial link pins between host and sensor port
`timescale 1ns/100ps
`default_nettype none
interface ssh_if;
	logic csb_h;
	logic csb_h_oe;
	logic sck;
	logic sdi_h_o;
	logic sdi_h_oe;
	logic sdi_d_o;
	logic sdi_d_oe;
	logic sdo_d_o;
	logic sdo_d_oe;
	logic addr_sel;
	logic csb_n;
	logic sdi;
	logic sdo;
	// Chip select is pulled up when nobody drives it
	assign csb_n = csb_h_oe ? csb_h : 1'b1;
	// Data line is pulled high; any enabled low driver wins
	assign sdi = ~((sdi_h_oe & ~sdi_h_o) | (sdi_d_oe & ~sdi_d_o));
	// Undriven data output shows the address strap level
	assign sdo = sdo_d_oe ? sdo_d_o : addr_sel;
	modport host (
		output csb_h, csb_h_oe, sck, sdi_h_o, sdi_h_oe,
		input  sdi, sdo
	);
	modport dev (
		input  csb_n, sck, sdi, sdo,
		output sdi_d_o, sdi_d_oe, sdo_d_o, sdo_d_oe
	);
endinterface
`default_nettype wire

// file: core/ssh_host.sv
// Host end: I2C or SPI master on the serial link
`timescale 1ns/100ps
`default_nettype none
module ssh_host (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rstn,
	ssh_if.host             bus,
	input  wire logic       i_cmd_valid,
	input  wire logic       i_cmd_spi,
	input  wire logic       i_cmd_read,
	input  wire logic       i_cmd_mode11,
	input  wire logic       i_cmd_three_wire,
	input  wire logic       i_cmd_sel,
	input  wire logic [7:0] i_cmd_addr,
	input  wire logic [7:0] i_cmd_wdata,
	input  wire logic [3:0] i_cmd_count,
	output logic            o_cmd_ready,
	output logic            o_rd_valid,
	output logic [7:0]      o_rd_data,
	output logic            o_done,
	output logic            o_nack
);
	ssh_pkg::ssh_host_e st;
	logic       c_spi;
	logic       c_read;
	logic       c_m11;
	logic       c_3w;
	logic       c_sel;
	logic [7:0] c_addr;
	logic [7:0] c_wdata;
	logic [3:0] c_cnt;
	logic [4:0] tick;
	logic [1:0] q;
	logic [3:0] bitn;
	logic [4:0] idx;
	logic [7:0] sh;
	logic [7:0] rx;
	logic       ackbit;
	logic [1:0] meta;
	logic [1:0] sync;
	logic       sck_q;
	logic       sda_q;
	logic       sda_oe_q;
	logic       csb_oe_q;

	function automatic logic [7:0] tx_byte(input logic [4:0] n);
		logic [7:0] b;
		b = c_wdata;
		if (c_spi) begin
			if (n == 5'h00)
				b = {c_read, c_addr[6:0]};
		end else if (n == 5'h00) begin
			b = {ssh_pkg::I2C_ADDR_HI, c_sel, ssh_pkg::RW_WRITE};
		end else if (n == 5'h01) begin
			b = c_addr;
		end else if (c_read) begin
			b = {ssh_pkg::I2C_ADDR_HI, c_sel, ssh_pkg::RW_READ};
		end
		tx_byte = b;
	endfunction

	wire       qend     = (tick == ssh_pkg::QUARTER_TOP);
	wire       rx_byte  = c_read && (idx >= (c_spi ? 5'h01 : 5'h03));
	wire [4:0] rd_last  = c_spi ? {1'b0, c_cnt} : 5'({1'b0, c_cnt} + 5'h02);
	wire [4:0] last_idx = c_read ? rd_last : (c_spi ? 5'h01 : 5'h02);
	wire [3:0] last_bit = c_spi ? ssh_pkg::BYTE_LAST : ssh_pkg::I2C_ACK_BIT;
	wire       ack_slot = !c_spi && (bitn == ssh_pkg::I2C_ACK_BIT);
	wire [1:0] samp_q   = c_spi ? 2'h3 : 2'h2;
	wire       sample   = (st == ssh_pkg::HS_BIT) && (tick == 5'h00) &&
		(q == samp_q);
	wire       in_bit   = (c_spi && !c_3w) ? sync[0] : sync[1];
	wire       i2c_clk  = (q == 2'h1) || (q == 2'h2);
	wire       rx_sda   = rx_byte ? (idx == last_idx) : 1'b1;
	wire       bit_sda  = ack_slot ? rx_sda : (rx_byte ? 1'b1 : sh[7]);
	wire       spi_hold = rx_byte && c_3w;
	wire       want_sck =
		(st == ssh_pkg::HS_IDLE)  ? 1'b1 :
		c_spi ? ((st == ssh_pkg::HS_BIT) ? q[1] : c_m11) :
		(st == ssh_pkg::HS_START) ? i2c_clk :
		(st == ssh_pkg::HS_BIT)   ? i2c_clk : (q != 2'h0);
	wire       want_sda =
		(st == ssh_pkg::HS_BIT)   ? bit_sda :
		c_spi ? 1'b1 :
		(st == ssh_pkg::HS_START) ? (q < 2'h2) :
		(st == ssh_pkg::HS_STOP)  ? (q >= 2'h2) : 1'b1;
	wire       want_oe  = c_spi ?
		((st != ssh_pkg::HS_IDLE) && !(st == ssh_pkg::HS_BIT && spi_hold)) :
		~want_sda;
	wire       want_csb = c_spi && (
		(st == ssh_pkg::HS_START && q != 2'h0) ||
		(st == ssh_pkg::HS_BIT) ||
		(st == ssh_pkg::HS_STOP && q == 2'h0));

	// Chip select is only driven low for SPI, released for I2C
	assign bus.csb_h    = 1'b0;
	assign bus.csb_h_oe = csb_oe_q;
	assign bus.sck      = sck_q;
	assign bus.sdi_h_o  = sda_q;
	assign bus.sdi_h_oe = sda_oe_q;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			meta     <= 2'h3;
			sync     <= 2'h3;
			sck_q    <= 1'b1;
			sda_q    <= 1'b1;
			sda_oe_q <= 1'b0;
			csb_oe_q <= 1'b0;
		end else begin
			meta     <= {bus.sdi, bus.sdo};
			sync     <= meta;
			sck_q    <= want_sck;
			sda_q    <= want_sda;
			sda_oe_q <= want_oe;
			csb_oe_q <= want_csb;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			st          <= ssh_pkg::HS_IDLE;
			{c_spi, c_read, c_m11, c_3w, c_sel} <= 5'h00;
			c_addr      <= 8'h00;
			c_wdata     <= 8'h00;
			c_cnt       <= 4'h0;
			tick        <= 5'h00;
			q           <= 2'h0;
			bitn        <= 4'h0;
			idx         <= 5'h00;
			sh          <= 8'h00;
			rx          <= 8'h00;
			ackbit      <= 1'b0;
			o_cmd_ready <= 1'b1;
			o_rd_valid  <= 1'b0;
			o_rd_data   <= 8'h00;
			o_done      <= 1'b0;
			o_nack      <= 1'b0;
		end else begin
			o_rd_valid <= 1'b0;
			o_done     <= 1'b0;
			if (sample && bitn <= ssh_pkg::BYTE_LAST)
				rx <= {rx[6:0], in_bit};
			else if (sample)
				ackbit <= in_bit;
			if (st == ssh_pkg::HS_IDLE) begin
				tick <= 5'h00;
				q    <= 2'h0;
				if (i_cmd_valid) begin
					{c_spi, c_read, c_m11} <= {i_cmd_spi, i_cmd_read, i_cmd_mode11};
					{c_3w, c_sel} <= {i_cmd_three_wire, i_cmd_sel};
					c_addr      <= i_cmd_addr;
					c_wdata     <= i_cmd_wdata;
					c_cnt       <= i_cmd_count;
					idx         <= 5'h00;
					o_nack      <= 1'b0;
					o_cmd_ready <= 1'b0;
					st          <= ssh_pkg::HS_START;
				end
			end else begin
				tick <= qend ? 5'h00 : tick + 5'h01;
				if (qend)
					q <= q + 2'h1;
				if (qend && q == 2'h3) begin
					case (st)
					ssh_pkg::HS_START: begin
						st   <= ssh_pkg::HS_BIT;
						bitn <= 4'h0;
						sh   <= tx_byte(idx);
					end
					ssh_pkg::HS_BIT: begin
						if (bitn != last_bit) begin
							bitn <= bitn + 4'h1;
							sh   <= {sh[6:0], 1'b0};
						end else begin
							if (rx_byte) begin
								o_rd_valid <= 1'b1;
								o_rd_data  <= rx;
							end
							if (!c_spi && !rx_byte && ackbit) begin
								o_nack <= 1'b1;
								st     <= ssh_pkg::HS_STOP;
							end else if (idx == last_idx) begin
								st <= ssh_pkg::HS_STOP;
							end else if (!c_spi && c_read && idx == 5'h01) begin
								idx <= 5'h02;
								st  <= ssh_pkg::HS_START;
							end else begin
								idx  <= idx + 5'h01;
								bitn <= 4'h0;
								sh   <= tx_byte(idx + 5'h01);
							end
						end
					end
					default: begin
						st          <= ssh_pkg::HS_IDLE;
						o_done      <= 1'b1;
						o_cmd_ready <= 1'b1;
					end
					endcase
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: core/ssh_device.sv
// Device end: I2C and SPI slave port of the sensor
`timescale 1ns/100ps
`default_nettype none
module ssh_device (
	input  wire logic       i_link_clk,
	input  wire logic       i_rstn,
	ssh_if.dev              bus,
	output logic            o_reg_wr,
	output logic [7:0]      o_reg_addr,
	output logic [7:0]      o_reg_wdata,
	input  wire logic [7:0] i_reg_rdata,
	output logic            o_three_wire_enable,
	output logic            o_i2c_disabled,
	output logic            o_spi_mode11
);
	ssh_pkg::ssh_i2c_e i2c_st;
	ssh_pkg::ssh_spi_e spi_ph;
	logic [3:0] meta;
	logic [3:0] sync;
	logic [3:0] prev;
	logic [3:0] cnt;
	logic [2:0] tx_cnt;
	logic [7:0] sh_in;
	logic [7:0] sh_out;
	logic       d_sdi_o;
	logic       d_sdi_oe;
	logic       d_sdo_o;
	logic       d_sdo_oe;

	function automatic logic is_cfg(input logic [7:0] a);
		is_cfg = (a == ssh_pkg::CFG_ADDR);
	endfunction

	// Synchronised pin levels and their previous values
	wire       csb       = sync[3];
	wire       sck       = sync[2];
	wire       sda       = sync[1];
	wire       strap     = sync[0];
	wire       pcsb      = prev[3];
	wire       psck      = prev[2];
	wire       psda      = prev[1];
	wire       sck_rise  = sck & ~psck;
	wire       sck_fall  = ~sck & psck;
	wire       csb_fall  = ~csb & pcsb;
	wire       spi_on    = ~csb;
	wire       i2c_start = sck & psck & ~sda & psda;
	wire       i2c_stop  = sck & psck & sda & ~psda;
	wire [7:0] next_in   = {sh_in[6:0], sda};
	wire [6:0] own_addr  = {ssh_pkg::I2C_ADDR_HI, strap};
	wire       addr_hit  = (sh_in[7:1] == own_addr);
	wire       ack_time  = (cnt == ssh_pkg::I2C_ACK_BIT);
	wire       out_load  = spi_on ? (tx_cnt == 3'h0) : (cnt == 4'h0);
	wire       out_bit   = out_load ? i_reg_rdata[7] : sh_out[7];
	wire [7:0] out_sh    = out_load ? {i_reg_rdata[6:0], 1'b0} :
		{sh_out[6:0], 1'b0};

	// The device has no clock output, only these data drivers
	assign bus.sdi_d_o  = d_sdi_o;
	assign bus.sdi_d_oe = d_sdi_oe;
	assign bus.sdo_d_o  = d_sdo_o;
	assign bus.sdo_d_oe = d_sdo_oe;

	always_ff @(posedge i_link_clk) begin
		if (!i_rstn) begin
			meta <= ssh_pkg::PIN_IDLE;
			sync <= ssh_pkg::PIN_IDLE;
			prev <= ssh_pkg::PIN_IDLE;
		end else begin
			meta <= {bus.csb_n, bus.sck, bus.sdi, bus.sdo};
			sync <= meta;
			prev <= sync;
		end
	end

	always_ff @(posedge i_link_clk) begin
		if (!i_rstn) begin
			i2c_st              <= ssh_pkg::DI_IDLE;
			spi_ph              <= ssh_pkg::SP_CTRL;
			cnt                 <= 4'h0;
			tx_cnt              <= 3'h0;
			sh_in               <= 8'h00;
			sh_out              <= 8'h00;
			o_reg_wr            <= 1'b0;
			o_reg_addr          <= ssh_pkg::RESET_ADDR;
			o_reg_wdata         <= 8'h00;
			o_three_wire_enable <= ssh_pkg::RESET_3W;
			o_i2c_disabled      <= 1'b0;
			o_spi_mode11        <= 1'b0;
			d_sdi_o             <= 1'b0;
			d_sdi_oe            <= 1'b0;
			d_sdo_o             <= 1'b0;
			d_sdo_oe            <= 1'b0;
		end else begin
			o_reg_wr <= 1'b0;
			if (spi_on) begin
				o_i2c_disabled <= 1'b1;
				i2c_st         <= ssh_pkg::DI_IDLE;
				if (csb_fall) begin
					o_spi_mode11 <= sck;
					spi_ph       <= ssh_pkg::SP_CTRL;
					cnt          <= 4'h0;
					tx_cnt       <= 3'h0;
					d_sdi_oe     <= 1'b0;
					d_sdo_oe     <= 1'b0;
				end else if (sck_rise) begin
					sh_in <= next_in;
					cnt   <= (cnt == ssh_pkg::BYTE_LAST) ? 4'h0 : cnt + 4'h1;
					if (cnt == ssh_pkg::BYTE_LAST) begin
						case (spi_ph)
						ssh_pkg::SP_CTRL: begin
							o_reg_addr <= {ssh_pkg::SPI_ADDR_MSB, next_in[6:0]};
							if (next_in[7] == ssh_pkg::RW_READ)
								spi_ph <= ssh_pkg::SP_READ;
							else
								spi_ph <= ssh_pkg::SP_DATA;
						end
						ssh_pkg::SP_DATA: begin
							o_reg_wr    <= 1'b1;
							o_reg_wdata <= next_in;
							spi_ph      <= ssh_pkg::SP_CTRL;
							if (is_cfg(o_reg_addr))
								o_three_wire_enable <= next_in[ssh_pkg::THREE_WIRE_BIT];
						end
						default: begin
							spi_ph <= ssh_pkg::SP_READ;
						end
						endcase
					end
				end else if (sck_fall && spi_ph == ssh_pkg::SP_READ) begin
					tx_cnt   <= tx_cnt + 3'h1;
					sh_out   <= out_sh;
					d_sdi_o  <= out_bit;
					d_sdo_o  <= out_bit;
					d_sdi_oe <= o_three_wire_enable;
					d_sdo_oe <= ~o_three_wire_enable;
					if (tx_cnt == 3'h0)
						o_reg_addr <= o_reg_addr + 8'h01;
				end
			end else if (o_i2c_disabled) begin
				spi_ph   <= ssh_pkg::SP_CTRL;
				d_sdi_oe <= 1'b0;
				d_sdo_oe <= 1'b0;
			end else begin
				d_sdi_o  <= 1'b0;
				d_sdo_oe <= 1'b0;
				if (i2c_start) begin
					i2c_st   <= ssh_pkg::DI_ADDR;
					cnt      <= 4'h0;
					d_sdi_oe <= 1'b0;
				end else if (i2c_stop) begin
					i2c_st   <= ssh_pkg::DI_IDLE;
					d_sdi_oe <= 1'b0;
				end else if (sck_rise && i2c_st != ssh_pkg::DI_IDLE) begin
					if (ack_time) begin
						cnt <= 4'h0;
						if (i2c_st == ssh_pkg::DI_RDAT && sda)
							i2c_st <= ssh_pkg::DI_SKIP;
					end else begin
						sh_in <= next_in;
						cnt   <= cnt + 4'h1;
					end
				end else if (sck_fall) begin
					case (i2c_st)
					ssh_pkg::DI_ADDR: begin
						d_sdi_oe <= ack_time && addr_hit;
						if (ack_time && !addr_hit)
							i2c_st <= ssh_pkg::DI_SKIP;
						else if (ack_time && sh_in[0] == ssh_pkg::RW_READ)
							i2c_st <= ssh_pkg::DI_RDAT;
						else if (ack_time)
							i2c_st <= ssh_pkg::DI_REG;
					end
					ssh_pkg::DI_REG: begin
						d_sdi_oe <= ack_time;
						if (ack_time) begin
							o_reg_addr <= sh_in;
							i2c_st     <= ssh_pkg::DI_WDAT;
						end
					end
					ssh_pkg::DI_WDAT: begin
						d_sdi_oe <= ack_time;
						if (ack_time) begin
							o_reg_wr    <= 1'b1;
							o_reg_wdata <= sh_in;
							i2c_st      <= ssh_pkg::DI_REG;
							if (is_cfg(o_reg_addr))
								o_three_wire_enable <= sh_in[ssh_pkg::THREE_WIRE_BIT];
						end
					end
					ssh_pkg::DI_RDAT: begin
						if (ack_time) begin
							d_sdi_oe <= 1'b0;
						end else begin
							d_sdi_oe <= ~out_bit;
							sh_out   <= out_sh;
						end
						if (cnt == 4'h0)
							o_reg_addr <= o_reg_addr + 8'h01;
					end
					default: begin
						d_sdi_oe <= 1'b0;
					end
					endcase
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: bench/ssh_link_checker.sv
// Checker of the device-side drivers on the serial link
`timescale 1ns/100ps
`default_nettype none
module ssh_link_checker (
	input wire logic i_link_clk,
	input wire logic i_rstn,
	input wire logic csb_n,
	input wire logic sck,
	input wire logic sdi_d_o,
	input wire logic sdi_d_oe,
	input wire logic sdo_d_o,
	input wire logic sdo_d_oe
);
	logic spi_seen;

	// Sticky once chip select was seen low
	always_ff @(posedge i_link_clk) begin
		if (!i_rstn)
			spi_seen <= 1'b0;
		else if (!csb_n)
			spi_seen <= 1'b1;
	end

	default clocking @(posedge i_link_clk); endclocking
	default disable iff (!i_rstn);

	a_i2c_low_only: assert property (
		!spi_seen && sdi_d_oe |-> !sdi_d_o)
		else $error("device drove data line high in I2C");
	a_strap_pin_input: assert property (
		!spi_seen |-> !sdo_d_oe)
		else $error("device drove address strap pin in I2C");
	a_release_deselect: assert property (
		(spi_seen && csb_n) [*8] |-> !sdi_d_oe && !sdo_d_oe)
		else $error("device drives a pin while deselected");
	a_no_dual_drive: assert property (
		spi_seen |-> !(sdi_d_oe && sdo_d_oe))
		else $error("device drives both data pins");
	a_sdo_fall_change: assert property (
		sdo_d_oe && $past(sdo_d_oe) && $changed(sdo_d_o) |-> !sck)
		else $error("data output changed while clock high");
	a_sdi_fall_change: assert property (
		spi_seen && sdi_d_oe && $past(sdi_d_oe) && $changed(sdi_d_o)
		|-> !sck)
		else $error("shared data pin changed while clock high");
	a_i2c_sda_steady: assert property (
		!spi_seen && sck && $past(sck) |-> $stable(sdi_d_oe))
		else $error("device moved data line while clock high");
	a_ack_hold_high: assert property (
		!spi_seen && $rose(sck) && sdi_d_oe |=> sdi_d_oe [*3])
		else $error("acknowledge dropped during clock high");

	c_i2c_ack: cover property (!spi_seen && sdi_d_oe);
	c_sdo_drive: cover property (sdo_d_oe);
	c_three_wire: cover property (spi_seen && sdi_d_oe);
endmodule
`default_nettype wire

// file: bench/sensor_serial_host_port_bench.sv
// Testbench joining host and device ends over the link
`timescale 1ns/100ps
`default_nettype none
module sensor_serial_host_port_bench;
	localparam int TIMEOUT = 80000;
	logic       i_ref_clk;
	logic       i_link_clk;
	logic       i_rstn;
	logic       cmd_valid;
	logic       cmd_spi;
	logic       cmd_read;
	logic       cmd_m11;
	logic       cmd_tw;
	logic       cmd_sel;
	logic [7:0] cmd_addr;
	logic [7:0] cmd_wdata;
	logic [3:0] cmd_count;
	logic       cmd_ready;
	logic       rd_valid;
	logic [7:0] rd_data;
	logic       done;
	logic       nack;
	logic       reg_wr;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic       tw_en;
	logic       i2c_dis;
	logic       m11;
	logic [7:0] last_addr;
	logic [7:0] last_data;
	logic [7:0] got[$];
	int         n_wr;
	int         n0;
	int         n_fail;
	int         num_checks;
	int         cycles;

	ssh_if lnk();

	ssh_host i_ssh_host (
		.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .bus(lnk.host),
		.i_cmd_valid(cmd_valid), .i_cmd_spi(cmd_spi),
		.i_cmd_read(cmd_read), .i_cmd_mode11(cmd_m11),
		.i_cmd_three_wire(cmd_tw), .i_cmd_sel(cmd_sel),
		.i_cmd_addr(cmd_addr), .i_cmd_wdata(cmd_wdata),
		.i_cmd_count(cmd_count), .o_cmd_ready(cmd_ready),
		.o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_done(done),
		.o_nack(nack)
	);
	ssh_device i_ssh_device (
		.i_link_clk(i_link_clk), .i_rstn(i_rstn), .bus(lnk.dev),
		.o_reg_wr(reg_wr), .o_reg_addr(reg_addr),
		.o_reg_wdata(reg_wdata), .i_reg_rdata(reg_rdata),
		.o_three_wire_enable(tw_en), .o_i2c_disabled(i2c_dis),
		.o_spi_mode11(m11)
	);
	ssh_link_checker i_ssh_link_checker (
		.i_link_clk(i_link_clk), .i_rstn(i_rstn), .csb_n(lnk.csb_n),
		.sck(lnk.sck), .sdi_d_o(lnk.sdi_d_o), .sdi_d_oe(lnk.sdi_d_oe),
		.sdo_d_o(lnk.sdo_d_o), .sdo_d_oe(lnk.sdo_d_oe)
	);

	// Register model: fixed pattern, writes recorded
	assign reg_rdata = reg_addr ^ 8'h5a;
	always @(posedge i_link_clk) begin
		if (reg_wr === 1'b1) begin
			last_addr <= reg_addr;
			last_data <= reg_wdata;
			n_wr <= n_wr + 1;
		end
	end

	initial begin
		i_ref_clk = 1'b0;
		forever #2.5 i_ref_clk = ~i_ref_clk;
	end
	initial begin
		i_link_clk = 1'b0;
		#3.3;
		forever #7.5 i_link_clk = ~i_link_clk;
	end

	task automatic report_and_stop;
		if (n_fail == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge i_ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == TIMEOUT) begin
			n_fail++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic do_reset;
		i_rstn <= 1'b0;
		repeat (12) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		repeat (20) @(posedge i_ref_clk);
	endtask

	// One host command, bytes read are queued in got
	task automatic run(input logic s, input logic r, input logic m,
		input logic t, input logic l, input logic [7:0] a,
		input logic [7:0] w, input logic [3:0] c);
		int k;
		got.delete();
		n0 = n_wr;
		@(posedge i_ref_clk);
		cmd_spi <= s;
		cmd_read <= r;
		cmd_m11 <= m;
		cmd_tw <= t;
		cmd_sel <= l;
		cmd_addr <= a;
		cmd_wdata <= w;
		cmd_count <= c;
		cmd_valid <= 1'b1;
		@(posedge i_ref_clk);
		cmd_valid <= 1'b0;
		for (k = 0; k < 20000; k++) begin
			@(posedge i_ref_clk);
			#1;
			if (k == 0)
				chk({7'h00, cmd_ready}, 8'h00);
			if (rd_valid === 1'b1)
				got.push_back(rd_data);
			if (done === 1'b1)
				break;
		end
		if (done !== 1'b1)
			chk(8'h00, 8'h01);
		chk({7'h00, cmd_ready}, 8'h01);
	endtask

	task automatic chk_rd(input logic [7:0] a, input int n);
		int k;
		chk(8'(got.size()), 8'(n));
		for (k = 0; k < n; k++)
			chk(got[k], (a + 8'(k)) ^ 8'h5a);
	endtask

	initial begin
		i_rstn = 1'b0;
		cmd_valid = 1'b0;
		{cmd_spi, cmd_read, cmd_m11, cmd_tw, cmd_sel} = 5'h00;
		cmd_addr = 8'h00;
		cmd_wdata = 8'h00;
		cmd_count = 4'h1;
		lnk.addr_sel = 1'b0;
		n_wr = 0;
		n_fail = 0;
		num_checks = 0;
		cycles = 0;
		do_reset();
		run(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h20, 8'ha5, 4'h1);
		chk({7'h00, nack}, 8'h00);
		chk(last_addr, 8'h20);
		chk(last_data, 8'ha5);
		chk(8'(n_wr - n0), 8'h01);
		run(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h21, 8'h3c, 4'h1);
		chk({7'h00, nack}, 8'h01);
		chk(8'(n_wr - n0), 8'h00);
		@(posedge i_ref_clk) lnk.addr_sel <= 1'b1;
		run(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h22, 8'hc3, 4'h1);
		chk({7'h00, nack}, 8'h00);
		chk(last_data, 8'hc3);
		@(posedge i_ref_clk) lnk.addr_sel <= 1'b0;
		run(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h30, 8'h00, 4'h3);
		chk_rd(8'h30, 3);
		chk({7'h00, i2c_dis}, 8'h00);
		run(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h44, 8'h99, 4'h1);
		chk(last_addr, 8'hc4);
		chk(last_data, 8'h99);
		chk({7'h00, m11}, 8'h00);
		chk({7'h00, i2c_dis}, 8'h01);
		run(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h70, 8'h00, 4'h3);
		chk_rd(8'hf0, 3);
		chk({7'h00, m11}, 8'h01);
		run(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'hf5, 8'h01, 4'h1);
		chk({7'h00, tw_en}, 8'h01);
		run(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 8'h7e, 8'h00, 4'h2);
		chk_rd(8'hfe, 2);
		run(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h23, 8'h11, 4'h1);
		chk({7'h00, nack}, 8'h01);
		chk(8'(n_wr - n0), 8'h00);
		do_reset();
		chk({7'h00, tw_en}, 8'h00);
		chk({7'h00, i2c_dis}, 8'h00);
		run(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h24, 8'h5e, 4'h1);
		chk({7'h00, nack}, 8'h00);
		chk(last_data, 8'h5e);
		report_and_stop();
	end
endmodule
`default_nettype wire
